// ==== hw/aphp_pkg.sv ====
// constants and types for the converter host port
`default_nettype none
package aphp_pkg;
  localparam int RESULT_W = 12;
  localparam int BUS_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_NS = 20;
  localparam int CONV_NS = 2700;
  localparam int ACQ_NS = 600;
  // longest time rounds down
  localparam int CONV_CYC = (CONV_NS / CLK_NS) < 1 ? 1 : (CONV_NS / CLK_NS);
  // least time rounds up
  localparam int ACQ_CYC = ((ACQ_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                           ((ACQ_NS + CLK_NS - 1) / CLK_NS);
  localparam int HI_NIB_LSB = 8;
  localparam int NIB_W = 4;
  localparam int SYNC_W = 3;
  localparam int CS_BIT = 2;
  localparam int RD_BIT = 1;
  localparam int HB_BIT = 0;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 3'h7;
  localparam logic [BUS_W-1:0] RESET_DATA = 16'h0000;
  typedef enum logic [2:0] {
    APHP_IDLE = 3'b001,
    APHP_CONV = 3'b010,
    APHP_ACQ = 3'b100
  } aphp_state_t;
endpackage : aphp_pkg
`default_nettype wire

// ==== hw/aphp_conv_if.sv ====
// handshake between the port control and the conversion timer
`default_nettype none
interface aphp_conv_if;
  logic start;
  logic done;
  logic [aphp_pkg::RESULT_W-1:0] sample;
  modport ctrl (output start, input done, input sample);
  modport core (input start, output done, output sample);
endinterface : aphp_conv_if
`default_nettype wire

// ==== hw/aphp_conv_core.sv ====
// conversion timer: fixed conversion time, result sampled from input
`default_nettype none
module aphp_conv_core
  import aphp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [RESULT_W-1:0] analog_code_i,
  aphp_conv_if.core conv
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  if (CONV_CYCLES < 1) begin : g_bad_conv
    $error("conversion cycles must be at least one");
  end
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic running;
  logic next_running;
  logic done_r;
  logic next_done;
  logic [RESULT_W-1:0] sample_r;
  logic [RESULT_W-1:0] next_sample;
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    next_sample = sample_r;
    if (!running && conv.start) begin
      next_running = 1'b1;
      next_count = CW'(CONV_CYCLES - 1);
      // hold the input at the start
      next_sample = analog_code_i;
    end else if (running) begin
      if (count == '0) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      count <= '0;
      running <= 1'b0;
      done_r <= 1'b0;
      sample_r <= '0;
    end else begin
      count <= next_count;
      running <= next_running;
      done_r <= next_done;
      sample_r <= next_sample;
    end
  end
  assign conv.done = done_r;
  assign conv.sample = sample_r;
endmodule : aphp_conv_core
`default_nettype wire

// ==== hw/aphp_host_port.sv ====
// host port of a 12-bit sampling converter: start, busy, result readout
// Notes on behaviour
// - start only when byte select, chip select and read all low
// - start requests ignored while a conversion runs
// - busy low for the whole conversion, high otherwise
// - result right-justified in 16-bit word, lsb on lowest output
// - byte select high steers top nibble onto outputs 3..0; a low-byte read returns the whole result on 11..0
// - outputs 11..8 carry top result bits whenever drivers are on; outputs 15..12 always low
// - wait-state start pulls busy low and shows previous result
// - end of conversion updates latches, new result and busy high on the same edge
// - high-byte read starts nothing; bits 11..8 on outputs 3..0, 7..4 low
// - pipelined low read starts conversion and returns previous result
// - two-byte pipelined: high byte first, then low byte starts next
// - conversion ends 2.72 us (136 cycles) after start; 600 ns acquisition follows
`default_nettype none
module aphp_host_port
  import aphp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int ACQ_CYCLES = ACQ_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic high_byte_select_i,
  input wire logic [RESULT_W-1:0] analog_code_i,
  output logic busy_n_o,
  output logic [BUS_W-1:0] result_outputs_o,
  output logic [BUS_W-1:0] result_outputs_oe_n_o
);
  localparam int AW = $clog2(ACQ_CYCLES + 1);

  // elaboration checks: values the logic cannot serve
  if (ACQ_CYCLES < 1) begin : g_bad_acq
    $error("acquisition cycles must be at least one");
  end
  if (CONV_CYCLES < 1) begin : g_bad_conv
    $error("conversion cycles must be at least one");
  end
  if (RESULT_W > BUS_W) begin : g_bad_width
    $error("result wider than the data outputs");
  end
  if (HI_NIB_LSB + NIB_W != RESULT_W) begin : g_bad_nibble
    $error("top nibble does not end at the result msb");
  end
  if (NIB_W > BYTE_W) begin : g_bad_byte
    $error("top nibble wider than a byte");
  end

  // pin synchronisers; strobes reset to their idle level
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] next_sync1;
  logic [SYNC_W-1:0] next_sync2;
  logic cs_n;
  logic rd_n;
  logic hbs;
  always_comb begin
    next_sync1 = sync1;
    next_sync1[CS_BIT] = chip_select_n_i;
    next_sync1[RD_BIT] = read_n_i;
    next_sync1[HB_BIT] = high_byte_select_i;
    next_sync2 = sync1;
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end
  assign cs_n = sync2[CS_BIT];
  assign rd_n = sync2[RD_BIT];
  assign hbs = sync2[HB_BIT];

  // sampled-input word; the source holds it steady around a start
  logic [RESULT_W-1:0] code_meta;
  logic [RESULT_W-1:0] code_hold;
  logic [RESULT_W-1:0] next_code_meta;
  logic [RESULT_W-1:0] next_code_hold;
  always_comb begin
    next_code_meta = analog_code_i;
    next_code_hold = code_meta;
  end
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      code_meta <= '0;
      code_hold <= '0;
    end else begin
      code_meta <= next_code_meta;
      code_hold <= next_code_hold;
    end
  end

  aphp_conv_if conv ();
  aphp_conv_core #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_core (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .analog_code_i(code_hold),
    .conv(conv.core)
  );

  function automatic logic [BUS_W-1:0] aphp_format(input logic [RESULT_W-1:0] r,
                                                   input logic high);
    logic [BUS_W-1:0] w;
    w = '0;
    // right-justified word
    w[RESULT_W-1:0] = r;
    if (high) begin
      // high byte on the low nibble, 7..4 low
      w[BYTE_W-1:0] = {{(BYTE_W-NIB_W){1'b0}}, r[RESULT_W-1:HI_NIB_LSB]};
    end
    return w;
  endfunction : aphp_format

  aphp_state_t state;
  aphp_state_t next_state;
  logic [AW-1:0] acq_count;
  logic [AW-1:0] next_acq_count;
  logic [RESULT_W-1:0] latch;
  logic [RESULT_W-1:0] next_latch;
  logic access_d;
  logic start_req;
  logic access;
  logic next_busy_n;
  logic [BUS_W-1:0] next_data;
  logic [BUS_W-1:0] next_oe_n;

  assign access = !cs_n && !rd_n;
  // three-way gate; byte select high never starts
  assign start_req = access && !access_d && !hbs;

  always_comb begin
    next_state = state;
    next_acq_count = acq_count;
    next_latch = latch;
    conv.start = 1'b0;
    case (state)
      APHP_IDLE: begin
        // start a conversion; same for pipelined reads
        if (start_req) begin
          conv.start = 1'b1;
          next_state = APHP_CONV;
        end
      end
      APHP_CONV: begin
        if (conv.done) begin
          // latch update and busy release take effect on the same edge
          next_latch = conv.sample;
          next_acq_count = AW'(ACQ_CYCLES - 1);
          next_state = APHP_ACQ;
        end
      end
      APHP_ACQ: begin
        // acquisition gap before the next start
        if (acq_count == '0) begin
          next_state = APHP_IDLE;
        end else begin
          next_acq_count = acq_count - 1'b1;
        end
      end
      default: next_state = APHP_IDLE;
    endcase
  end

  always_comb begin
    // busy low exactly while converting; high otherwise
    next_busy_n = !(next_state == APHP_CONV);
    next_data = aphp_format(next_latch, hbs);
    // top nibble always on the upper outputs
    next_data[RESULT_W-1:HI_NIB_LSB] = next_latch[RESULT_W-1:HI_NIB_LSB];
    next_oe_n = access ? '0 : '1;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state <= APHP_IDLE;
      acq_count <= '0;
      latch <= '0;
      access_d <= 1'b0;
      busy_n_o <= 1'b1;
      result_outputs_o <= RESET_DATA;
      result_outputs_oe_n_o <= '1;
    end else begin
      state <= next_state;
      acq_count <= next_acq_count;
      latch <= next_latch;
      access_d <= access;
      busy_n_o <= next_busy_n;
      result_outputs_o <= next_data;
      result_outputs_oe_n_o <= next_oe_n;
    end
  end
endmodule : aphp_host_port
`default_nettype wire

// ==== verification/aphp_host_port_props.sv ====
// pin-level assertions for the converter host port
`default_nettype none
module aphp_host_port_props
  import aphp_pkg::*;
#(parameter int CONV_CYCLES = CONV_CYC, parameter int ACQ_CYCLES = ACQ_CYC) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic high_byte_select_i,
  input wire logic busy_n_o,
  input wire logic [BUS_W-1:0] result_outputs_o,
  input wire logic [BUS_W-1:0] result_outputs_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic start_pins;
  assign start_pins = !chip_select_n_i && !read_n_i && !high_byte_select_i;
  // low count sized for the short conversion of 8
  sequence s_conv_low;
    !busy_n_o [*8];
  endsequence
  a_start_cause: assert property ($fell(busy_n_o) |-> $past(start_pins, 3))
    else $error("busy fell without start");
  a_conv_len: assert property ($fell(busy_n_o) |-> s_conv_low ##1 !busy_n_o ##1 busy_n_o)
    else $error("busy low length wrong");
  a_acq_gap: assert property ($rose(busy_n_o) |-> busy_n_o [*3])
    else $error("restart too soon");
  a_rst_idle: assert property ($rose(resetn_i) |-> busy_n_o [*3])
    else $error("busy low after reset");
  a_upper_zero: assert property (!result_outputs_oe_n_o[0] |-> result_outputs_o[15:12] == 4'h0)
    else $error("upper bits driven");
  a_oe_uniform: assert property (result_outputs_oe_n_o == 16'h0000 || result_outputs_oe_n_o == 16'hFFFF)
    else $error("enables differ");
  a_oe_idle: assert property (chip_select_n_i [*4] |-> result_outputs_oe_n_o[0])
    else $error("drivers on while deselected");
  a_high_nibble: assert property (!result_outputs_oe_n_o[0] && high_byte_select_i &&
    $past(high_byte_select_i, 3) |-> result_outputs_o[7:4] == 4'h0 &&
    result_outputs_o[3:0] == result_outputs_o[11:8])
    else $error("high byte layout wrong");
endmodule : aphp_host_port_props
`default_nettype wire

// ==== verification/aphp_host_model.sv ====
// host bus model: read cycles on chip select, read and byte select
`default_nettype none
module aphp_host_model
  import aphp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic busy_n_i,
  input wire logic [BUS_W-1:0] data_i,
  input wire logic [BUS_W-1:0] oe_n_i,
  output logic cs_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic hbs_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic rd(input logic h, input logic w, output logic [BUS_W-1:0] d0,
                    output logic b0, output logic [BUS_W-1:0] d1);
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    hbs_o <= h;
    repeat (4) @(posedge mclk_i);
    #1;
    // undriven bits read back inverted
    d0 = data_i ^ oe_n_i;
    b0 = busy_n_i;
    for (int i = 0; i < 300 && w && busy_n_i !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    d1 = data_i ^ oe_n_i;
    @(posedge mclk_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask : rd
endmodule : aphp_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the converter host port
`default_nettype none
module tb;
  import aphp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cs_n, rd_n, hbs, busy_n, b0;
  logic [RESULT_W-1:0] code = 12'h000;
  logic [BUS_W-1:0] data, oe_n, d0, d1;
  int error_cnt = 0;
  int check_count = 0;
  aphp_host_port #(.CONV_CYCLES(8), .ACQ_CYCLES(2)) aphp_host_port_i (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .chip_select_n_i(cs_n), .read_n_i(rd_n), .high_byte_select_i(hbs),
    .analog_code_i(code), .busy_n_o(busy_n), .result_outputs_o(data),
    .result_outputs_oe_n_o(oe_n));
  aphp_host_model aphp_host_model_i (.mclk_i(mclk_i), .busy_n_i(busy_n), .data_i(data),
    .oe_n_i(oe_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .hbs_o(hbs));
  initial forever #10 mclk_i = ~mclk_i;
  task automatic chk(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic t_wait;
    code <= 12'hA5C;
    aphp_host_model_i.rd(1'b0, 1'b1, d0, b0, d1);
    chk({15'h0000, b0}, 16'h0000);
    chk(d0, 16'h0000);
    chk(d1, 16'h0A5C);
    @(posedge mclk_i);
    #1;
    chk(oe_n, 16'hFFFF);
    aphp_host_model_i.rd(1'b1, 1'b0, d0, b0, d1);
    chk({15'h0000, b0}, 16'h0001);
    chk(d0, 16'h0A0A);
  endtask : t_wait
  task automatic t_pipe;
    code <= 12'h3C7;
    aphp_host_model_i.rd(1'b0, 1'b0, d0, b0, d1);
    chk(d0, 16'h0A5C);
    repeat (20) @(posedge mclk_i);
    aphp_host_model_i.rd(1'b1, 1'b0, d0, b0, d1);
    chk(d0, 16'h0303);
    aphp_host_model_i.rd(1'b0, 1'b0, d0, b0, d1);
    chk(d0, 16'h03C7);
    repeat (20) @(posedge mclk_i);
  endtask : t_pipe
  task automatic t_ignore;
    code <= 12'h111;
    aphp_host_model_i.rd(1'b0, 1'b0, d0, b0, d1);
    chk(d0, 16'h03C7);
    code <= 12'h222;
    aphp_host_model_i.rd(1'b0, 1'b0, d0, b0, d1);
    repeat (20) @(posedge mclk_i);
    aphp_host_model_i.rd(1'b0, 1'b1, d0, b0, d1);
    chk(d0, 16'h0111);
    chk(d1, 16'h0222);
  endtask : t_ignore
  initial begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk({15'h0000, busy_n}, 16'h0001);
    chk(oe_n, 16'hFFFF);
    @(posedge mclk_i);
    t_wait();
    t_pipe();
    t_ignore();
    report_and_stop();
  end
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
bind aphp_host_port aphp_host_port_props #(.CONV_CYCLES(CONV_CYCLES), .ACQ_CYCLES(ACQ_CYCLES))
  aphp_host_port_props_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .chip_select_n_i(chip_select_n_i), .read_n_i(read_n_i),
  .high_byte_select_i(high_byte_select_i), .busy_n_o(busy_n_o),
  .result_outputs_o(result_outputs_o), .result_outputs_oe_n_o(result_outputs_oe_n_o));
`default_nettype wire
